// ---- bench/t1fs_status_regs_properties.sv ----
// Purpose: bus and read-back properties of the status page
// Assumes: one wait state per access, bench reads re-presented two edges apart
// Notes: bound from the bench top file
`timescale 1ns/1ps
module t1fs_status_regs_properties
  import t1fs_pkg::*;
#(
  parameter logic [7:0] DEV_CODE = DEV_CODE_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [3:0] BYTEENABLE,
  input wire logic [31:0] READDATA,
  input wire logic WAITREQUEST,
  input wire logic [7:0] PEAK_LEVEL,
  input wire t1fs_alarm_t ALARM_EVENTS,
  input wire t1fs_cnt_ev_t COUNT_EVENTS
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // ==========================================
  // handshake
  a_req_answer: assert property ((READ || WRITE) && WAITREQUEST |=> !WAITREQUEST)
    else $error("request not answered next cycle");
  a_one_wait: assert property (!WAITREQUEST |=> WAITREQUEST)
    else $error("wait low longer than one cycle");
  a_idle_waits: assert property (!READ && !WRITE |=> WAITREQUEST)
    else $error("wait dropped without request");
  a_upper_zero: assert property (READDATA[31:8] == 24'h000000)
    else $error("upper read data not zero");
  // ==========================================
  // read-back values
  a_id_fixed: assert property (READ && WAITREQUEST && ADDRESS == 8'h7C |=> READDATA[7:0] == DEV_CODE)
    else $error("identification value wrong");
  a_unused_zero: assert property (READ && WAITREQUEST && ADDRESS[7:2] == 6'h3A |=> READDATA == 32'h00000000)
    else $error("unused offset not zero");
  // stable input guard: the peak register lags the pin by one cycle
  a_peak_follow: assert property (
    READ && WAITREQUEST && ADDRESS == 8'h74 && $stable(PEAK_LEVEL) && !$past(RST)
    |=> READDATA[7:0] == $past(PEAK_LEVEL))
    else $error("peak level read wrong");
  a_alarm_cleared: assert property (
    READ && !WAITREQUEST && ADDRESS == 8'hC8 && $past(ALARM_EVENTS) == 8'h00
    && ALARM_EVENTS == 8'h00 ##1 ALARM_EVENTS == 8'h00 ##1 READ && WAITREQUEST && ADDRESS == 8'hC8
    |=> READDATA == 32'h00000000)
    else $error("alarm latch not cleared by read");
  a_mf_cleared: assert property (
    WRITE && !WAITREQUEST && ADDRESS == 8'hC0 && BYTEENABLE[0] && !COUNT_EVENTS.crc_mf
    ##1 !COUNT_EVENTS.crc_mf ##1 READ && WAITREQUEST && ADDRESS == 8'hC4 |=> READDATA == 32'h00000000)
    else $error("multiframe count not cleared by write");
endmodule : t1fs_status_regs_properties

// ---- bench/tb.sv ----
// Purpose: register-level test of the status page
// Assumes: frame period shortened to 8 cycles
// Notes: events are one-cycle pulses from the bench
`timescale 1ns/1ps
module tb;
  import t1fs_pkg::*;
  // arbitrary identification value
  localparam logic [7:0] ID = 8'h3C;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [7:0] ADDRESS = 8'h00;
  logic READ = 1'b0;
  logic WRITE = 1'b0;
  logic [31:0] WRITEDATA = 32'h00000000;
  logic [31:0] READDATA;
  logic WAITREQUEST;
  logic [4:0] TX_SLOT_OFFSET = 5'h15;
  logic [2:0] TX_BIT_OFFSET = 3'h5;
  logic [7:0] PEAK_LEVEL = 8'hC3;
  t1fs_alarm_t ALARM_EVENTS = '0;
  t1fs_irq_t IRQ_EVENTS = '0;
  t1fs_cnt_ev_t COUNT_EVENTS = '0;
  logic [7:0] IRQ_WORD1 = 8'h96;
  logic [7:0] IRQ_WORD3 = 8'h69;
  logic [3:0] BYTEENABLE = 4'hF;
  int miscompares = 0;
  int total_checks = 0;
  t1fs_status_regs #(.FRAME_CYC(8), .DEV_CODE(ID)) u_dut (.CLK(CLK), .RST(RST), .ADDRESS(ADDRESS),
    .READ(READ), .WRITE(WRITE), .WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
    .WAITREQUEST(WAITREQUEST), .TX_SLOT_OFFSET(TX_SLOT_OFFSET), .TX_BIT_OFFSET(TX_BIT_OFFSET),
    .PEAK_LEVEL(PEAK_LEVEL), .ALARM_EVENTS(ALARM_EVENTS), .IRQ_EVENTS(IRQ_EVENTS),
    .COUNT_EVENTS(COUNT_EVENTS), .IRQ_WORD1(IRQ_WORD1), .IRQ_WORD3(IRQ_WORD3));
  initial begin
    forever #5 CLK = ~CLK;
  end
  // ==========================================
  // bus access: values sampled at the edge before design updates land
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge CLK);
    READ <= !w;
    WRITE <= w;
    ADDRESS <= a;
    WRITEDATA <= {24'h000000, d};
    // no local limit: only the watchdog ends a hung access
    do begin
      @(posedge CLK);
    end while (WAITREQUEST !== 1'b0);
    q = READDATA[7:0];
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask : bus
  task automatic check(input logic [7:0] a, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH reg %h expected %h seen %h", a, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(a, q, e);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic ev(input logic [23:0] m);
    @(posedge CLK);
    {ALARM_EVENTS, IRQ_EVENTS, COUNT_EVENTS} <= m;
    @(posedge CLK);
    {ALARM_EVENTS, IRQ_EVENTS, COUNT_EVENTS} <= 24'h000000;
  endtask : ev
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // ==========================================
  // tests
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    rd(8'h7C, ID);
    wr(8'h7C, 8'hFF);
    rd(8'h7C, ID);
    rd(8'h74, 8'hC3);
    rd(8'hE8, 8'h00);
    rd(8'hF0, 8'h96);
    rd(8'hF8, 8'h69);
    rd(8'h60, 8'hAD);
    TX_SLOT_OFFSET <= 5'h0A;
    TX_BIT_OFFSET <= 3'h2;
    repeat (9) @(posedge CLK);
    rd(8'h60, 8'h52);
    wr(8'hC0, 8'h00);
    rd(8'hC4, 8'h00);
    repeat (3) ev(24'h000004);
    repeat (2) ev(24'h000002);
    rd(8'hC0, 8'h03);
    rd(8'hC4, 8'h02);
    wr(8'hC0, 8'hFF);
    rd(8'hC4, 8'h00);
    rd(8'hC0, 8'hFF);
    // a write without the low byte lane must leave the counter alone
    BYTEENABLE <= 4'hE;
    wr(8'hC0, 8'h55);
    BYTEENABLE <= 4'hF;
    rd(8'hC0, 8'hFF);
    // wrap of the error counter must raise its overflow bit
    ev(24'h000004);
    rd(8'hC0, 8'h00);
    rd(8'hFC, 8'h04);
    rd(8'hFC, 8'h00);
    rd(8'hF4, 8'h04);
    rd(8'hF4, 8'h00);
    for (int i = 0; i < 8; i++) begin
      ev(24'h010100 << i);
      rd(8'hC8, 8'h01 << i);
      rd(8'hC8, 8'h00);
      rd(8'hEC, 8'h01 << i);
    end
    // one pulse on every other counter, each read back at its own index
    ev(24'h0000F9);
    rd(8'hCC, 8'h01);
    rd(8'hD0, 8'h11);
    rd(8'hD4, 8'h01);
    rd(8'hD8, 8'h00);
    rd(8'hDC, 8'h01);
    rd(8'hE0, 8'h00);
    rd(8'hE4, 8'h01);
    report_and_stop();
  end
  initial begin
    repeat (3000) @(posedge CLK);
    miscompares++;
    report_and_stop();
  end
endmodule : tb
bind t1fs_status_regs t1fs_status_regs_properties #(.DEV_CODE(DEV_CODE)) u_props (.CLK(CLK), .RST(RST),
  .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE), .BYTEENABLE(BYTEENABLE), .READDATA(READDATA),
  .WAITREQUEST(WAITREQUEST), .PEAK_LEVEL(PEAK_LEVEL), .ALARM_EVENTS(ALARM_EVENTS), .COUNT_EVENTS(COUNT_EVENTS));

// ---- hdl/t1fs_pkg.sv ----
// Purpose: constants and types of the T1 framer status page block
// Assumes: 100 MHz CLK, Avalon-MM slave with 32-bit data
// Notes: shared by the design and the bench
// Function
// - slot count in bits 7..3
// - bit count in bits 2..0
// - phase word refreshed every 250 us
// - peak detector conversion readable
// - fixed identification code, writes ignored
// - status page decodes 10H..1FH, 1AH unused
// - PRBS error counter counts each error
// - multiframe counter counts each CRC multiframe
// - PRBS counter write clears multiframe counter
// - bit 7 long D4 yellow alarm
// - bit 6 short D4 yellow alarm
// - bit 5 alternate D4 yellow alarm
// - bit 4 ESF yellow alarm
// - bit 3 blue all-ones alarm
// - bit 2 pulse density violation
// - bit 1 loop-up code received
// - bit 0 loop-down code received
// - alarm bits held until read clears
// - interrupt word zero gathers eight flags
// - overflow latch at 1FH for counters
package t1fs_pkg;
  // =====================================================
  // register indices (byte address = 4 * index, plus 80H on page four)
  localparam logic [4:0] IDX_SLIP_PHASE = 5'h18;
  localparam logic [4:0] IDX_PEAK = 5'h1D;
  localparam logic [4:0] IDX_DEV_ID = 5'h1F;
  localparam logic [4:0] IDX_PRBS_ERR = 5'h10;
  localparam logic [4:0] IDX_PRBS_MF = 5'h11;
  localparam logic [4:0] IDX_ALARM = 5'h12;
  localparam logic [4:0] IDX_FRM_ERR = 5'h13;
  localparam logic [4:0] IDX_OOF_COFA = 5'h14;
  localparam logic [4:0] IDX_MF_LOSS = 5'h15;
  localparam logic [4:0] IDX_LCV_HI = 5'h16;
  localparam logic [4:0] IDX_LCV_LO = 5'h17;
  localparam logic [4:0] IDX_CRC_HI = 5'h18;
  localparam logic [4:0] IDX_CRC_LO = 5'h19;
  localparam logic [4:0] IDX_UNUSED = 5'h1A;
  localparam logic [4:0] IDX_IRQ0 = 5'h1B;
  localparam logic [4:0] IDX_IRQ1 = 5'h1C;
  localparam logic [4:0] IDX_IRQ2 = 5'h1D;
  localparam logic [4:0] IDX_IRQ3 = 5'h1E;
  localparam logic [4:0] IDX_OVF = 5'h1F;
  localparam logic [4:0] IDX_PAGE_LO = 5'h10;
  // page select: address bit 7 (0 page three, 1 page four)
  localparam int ADDR_PAGE_BIT = 7;
  // =====================================================
  // field positions
  localparam int SLOT_LSB = 3;
  localparam int BIT_LSB = 0;
  // =====================================================
  // reset values and identity
  localparam logic [7:0] RST_BYTE = 8'h00;
  // arbitrary value, not a real part code
  localparam logic [7:0] DEV_CODE_DEFAULT = 8'h5A;
  // =====================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FRAME_PERIOD_NS = 250000;
  localparam int FRAME_CYCLES = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  // =====================================================
  // types
  typedef enum logic [1:0] {
    BS_IDLE = 2'b01,
    BS_ACK = 2'b10
  } t1fs_bus_t;
  typedef struct packed {
    logic d4_yellow_long;
    logic d4_yellow_short;
    logic d4_alt_yellow;
    logic esf_yellow;
    logic all_ones_alarm;
    logic density_violation;
    logic loop_up_code;
    logic loop_down_code;
  } t1fs_alarm_t;
  typedef struct packed {
    logic frame_sync_change;
    logic mf_sync_change;
    logic biom_transition;
    logic ais;
    logic loss_of_signal;
    logic severe_error;
    logic tx_slip;
    logic rx_slip;
  } t1fs_irq_t;
  typedef struct packed {
    logic framing_err;
    logic crc_err;
    logic out_of_frame;
    logic align_change;
    logic line_code;
    logic prbs_err;
    logic crc_mf;
    logic mf_sync_loss;
  } t1fs_cnt_ev_t;
endpackage : t1fs_pkg

// ---- hdl/t1fs_status_regs.sv ----
// Purpose: status page registers of a T1 framer
// Assumes: event inputs are one-cycle pulses synchronous to CLK
// Notes: one-cycle wait state on every access
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module t1fs_status_regs
  import t1fs_pkg::*;
#(
  parameter int FRAME_CYC = FRAME_CYCLES,
  parameter logic [7:0] DEV_CODE = DEV_CODE_DEFAULT
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic [4:0] TX_SLOT_OFFSET,
  input wire logic [2:0] TX_BIT_OFFSET,
  input wire logic [7:0] PEAK_LEVEL,
  input wire t1fs_alarm_t ALARM_EVENTS,
  input wire t1fs_irq_t IRQ_EVENTS,
  input wire t1fs_cnt_ev_t COUNT_EVENTS,
  input wire logic [7:0] IRQ_WORD1,
  input wire logic [7:0] IRQ_WORD3
);

  // =====================================================
  // functions
  function automatic logic [8:0] inc8(input logic [7:0] v, input logic en);
    inc8 = {1'b0, v} + {8'h00, en};
  endfunction : inc8

  function automatic logic [4:0] inc4(input logic [3:0] v, input logic en);
    inc4 = {1'b0, v} + {4'h0, en};
  endfunction : inc4

  // =====================================================
  // declarations
  t1fs_bus_t bus_q;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] rbyte_d;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic page4;
  logic [4:0] idx;
  logic [7:0] clr_mask;
  logic [15:0] frame_cnt_q;
  logic [7:0] phase_q;
  logic [7:0] peak_q;
  logic [7:0] prbs_err_cnt_q;
  logic [8:0] prbs_err_inc;
  logic [7:0] prbs_mf_cnt_q;
  logic [8:0] prbs_mf_inc;
  logic [7:0] alarm_q;
  logic [7:0] irq0_q;
  logic [7:0] irq2_q;
  logic [7:0] ovf_q;
  logic [7:0] ovf_ev;
  logic [7:0] frm_cnt_q;
  logic [8:0] frm_inc;
  logic [3:0] oof_cnt_q;
  logic [4:0] oof_inc;
  logic [3:0] cofa_cnt_q;
  logic [4:0] cofa_inc;
  logic [7:0] mfl_cnt_q;
  logic [8:0] mfl_inc;
  logic [15:0] lcv_cnt_q;
  logic [16:0] lcv_inc;
  logic [15:0] crc_cnt_q;
  logic [16:0] crc_inc;
  logic [7:0] irq1_q;
  logic [7:0] irq3_q;

  // =====================================================
  // bus handshake
  assign page4 = ADDRESS[ADDR_PAGE_BIT];
  assign idx = ADDRESS[6:2];
  assign acc = (READ || WRITE) && bus_q == BS_ACK;
  assign wr_acc = acc && WRITE && BYTEENABLE[0];
  assign rd_acc = acc && READ;

  always_ff @(posedge CLK) begin
    if (RST) begin
      bus_q <= BS_IDLE;
      wait_q <= 1'b1;
    end else begin
      case (bus_q)
        BS_IDLE: begin
          if (READ || WRITE) begin
            bus_q <= BS_ACK;
            wait_q <= 1'b0;
          end
        end
        BS_ACK: begin
          bus_q <= BS_IDLE;
          wait_q <= 1'b1;
        end
        default: begin
          bus_q <= BS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // =====================================================
  // read mux
  always_comb begin
    rbyte_d = RST_BYTE;
    if (!page4) begin
      case (idx)
        IDX_SLIP_PHASE: rbyte_d = phase_q;
        IDX_PEAK: rbyte_d = peak_q;
        IDX_DEV_ID: rbyte_d = DEV_CODE;
        default: rbyte_d = RST_BYTE;
      endcase
    end else begin
      case (idx)
        IDX_PRBS_ERR: rbyte_d = prbs_err_cnt_q;
        IDX_PRBS_MF: rbyte_d = prbs_mf_cnt_q;
        IDX_ALARM: rbyte_d = alarm_q;
        IDX_FRM_ERR: rbyte_d = frm_cnt_q;
        IDX_OOF_COFA: rbyte_d = {oof_cnt_q, cofa_cnt_q};
        IDX_MF_LOSS: rbyte_d = mfl_cnt_q;
        IDX_LCV_HI: rbyte_d = lcv_cnt_q[15:8];
        IDX_LCV_LO: rbyte_d = lcv_cnt_q[7:0];
        IDX_CRC_HI: rbyte_d = crc_cnt_q[15:8];
        IDX_CRC_LO: rbyte_d = crc_cnt_q[7:0];
        IDX_UNUSED: rbyte_d = RST_BYTE;
        IDX_IRQ0: rbyte_d = irq0_q;
        IDX_IRQ1: rbyte_d = irq1_q;
        IDX_IRQ2: rbyte_d = irq2_q;
        IDX_IRQ3: rbyte_d = irq3_q;
        IDX_OVF: rbyte_d = ovf_q;
        default: rbyte_d = RST_BYTE;
      endcase
    end
  end

  // data captured when the wait state is dropped, so it stands at the accept edge
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_q == BS_IDLE && READ) begin
      rdata_q <= {24'h00_0000, rbyte_d};
    end
  end

  // only bits shown to software are cleared; later events survive
  assign clr_mask = rd_acc ? rdata_q[7:0] : 8'h00;

  // =====================================================
  // frame timer and sampled status
  always_ff @(posedge CLK) begin
    if (RST) begin
      frame_cnt_q <= 16'h0000;
    end else if (frame_cnt_q == 16'(FRAME_CYC - 1)) begin
      frame_cnt_q <= 16'h0000;
    end else begin
      frame_cnt_q <= frame_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      phase_q <= RST_BYTE;
    end else if (frame_cnt_q == 16'(FRAME_CYC - 1)) begin
      phase_q[7:SLOT_LSB] <= TX_SLOT_OFFSET;
      phase_q[SLOT_LSB-1:BIT_LSB] <= TX_BIT_OFFSET;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      peak_q <= RST_BYTE;
    end else begin
      peak_q <= PEAK_LEVEL;
    end
  end

  // =====================================================
  // PRBS counters
  assign prbs_err_inc = inc8(prbs_err_cnt_q, COUNT_EVENTS.prbs_err);
  assign prbs_mf_inc = inc8(prbs_mf_cnt_q, COUNT_EVENTS.crc_mf);

  always_ff @(posedge CLK) begin
    if (RST) begin
      prbs_err_cnt_q <= RST_BYTE;
    end else if (wr_acc && page4 && idx == IDX_PRBS_ERR) begin
      prbs_err_cnt_q <= WRITEDATA[7:0];
    end else begin
      prbs_err_cnt_q <= prbs_err_inc[7:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      prbs_mf_cnt_q <= RST_BYTE;
    end else if (wr_acc && page4 && idx == IDX_PRBS_ERR) begin
      prbs_mf_cnt_q <= RST_BYTE;
    end else begin
      prbs_mf_cnt_q <= prbs_mf_inc[7:0];
    end
  end

  // =====================================================
  // error and event counters
  assign frm_inc = inc8(frm_cnt_q, COUNT_EVENTS.framing_err);
  assign oof_inc = inc4(oof_cnt_q, COUNT_EVENTS.out_of_frame);
  assign cofa_inc = inc4(cofa_cnt_q, COUNT_EVENTS.align_change);
  assign mfl_inc = inc8(mfl_cnt_q, COUNT_EVENTS.mf_sync_loss);
  assign lcv_inc = {1'b0, lcv_cnt_q} + {16'h0000, COUNT_EVENTS.line_code};
  assign crc_inc = {1'b0, crc_cnt_q} + {16'h0000, COUNT_EVENTS.crc_err};

  always_ff @(posedge CLK) begin
    if (RST) begin
      frm_cnt_q <= RST_BYTE;
      oof_cnt_q <= 4'h0;
      cofa_cnt_q <= 4'h0;
      mfl_cnt_q <= RST_BYTE;
      lcv_cnt_q <= 16'h0000;
      crc_cnt_q <= 16'h0000;
    end else begin
      frm_cnt_q <= frm_inc[7:0];
      oof_cnt_q <= oof_inc[3:0];
      cofa_cnt_q <= cofa_inc[3:0];
      mfl_cnt_q <= mfl_inc[7:0];
      lcv_cnt_q <= lcv_inc[15:0];
      crc_cnt_q <= crc_inc[15:0];
    end
  end

  assign ovf_ev = {frm_inc[8], crc_inc[16], oof_inc[4], cofa_inc[4],
                   lcv_inc[16], prbs_err_inc[8], prbs_mf_inc[8], mfl_inc[8]};

  // =====================================================
  // sticky latches, set wins over read clear; IRQ_WORD1 and IRQ_WORD3 are plain registered copies
  always_ff @(posedge CLK) begin
    if (RST) begin
      alarm_q <= RST_BYTE;
    end else if (page4 && idx == IDX_ALARM) begin
      alarm_q <= (alarm_q & ~clr_mask) | ALARM_EVENTS;
    end else begin
      alarm_q <= alarm_q | ALARM_EVENTS;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq0_q <= RST_BYTE;
    end else if (page4 && idx == IDX_IRQ0) begin
      irq0_q <= (irq0_q & ~clr_mask) | IRQ_EVENTS;
    end else begin
      irq0_q <= irq0_q | IRQ_EVENTS;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq2_q <= RST_BYTE;
    end else if (page4 && idx == IDX_IRQ2) begin
      irq2_q <= (irq2_q & ~clr_mask) | ovf_ev;
    end else begin
      irq2_q <= irq2_q | ovf_ev;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      ovf_q <= RST_BYTE;
    end else if (page4 && idx == IDX_OVF) begin
      ovf_q <= (ovf_q & ~clr_mask) | ovf_ev;
    end else begin
      ovf_q <= ovf_q | ovf_ev;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      irq1_q <= RST_BYTE;
      irq3_q <= RST_BYTE;
    end else begin
      irq1_q <= IRQ_WORD1;
      irq3_q <= IRQ_WORD3;
    end
  end

  // =====================================================
  // outputs
  assign READDATA = rdata_q;
  assign WAITREQUEST = wait_q;

endmodule : t1fs_status_regs
